//--- hdl/ddsl_top.sv
`timescale 1ns/10ps
module ddsl_top (
	input wire logic SYS_CLK_I,                 // system clock, 40 MHz
	input wire logic ARST_N_I,                  // asynchronous reset, active low
	input wire logic SCLK_I,                    // serial clock from the host
	input wire logic FRAME_SELECT_N_I,          // frame select, active low
	input wire logic SERIAL_DATA_IN_I,          // serial data input
	input wire logic LOAD_OUTPUTS_N_I,          // output load strobe, active low
	input wire logic CODING_SELECT_I,           // high offset binary, low twos complement
	input wire logic [1:0] BIPOLAR_I,           // per channel bipolar range select
	output logic [15:0] DAC_A_O,                // output register, channel a
	output logic [15:0] DAC_B_O,                // output register, channel b
	output logic OUT_UPDATE_O,                  // pulse when an output register changes
	output logic FIFO_FULL_O,                   // word buffer full
	output logic OVERRUN_O                      // sticky: a frame word was lost
);
	// ---------------------------------------------------------------
	// link domain: shift register and frame capture
	// ---------------------------------------------------------------
	logic [ddsl_pkg::WORD_W-1:0] shift_r;
	logic [ddsl_pkg::WORD_W-1:0] hold_r;
	logic frame_tog_r;

	always_ff @(negedge SCLK_I) begin
		if (!FRAME_SELECT_N_I) begin
			shift_r <= {shift_r[ddsl_pkg::WORD_W-2:0], SERIAL_DATA_IN_I};
		end
	end

	// the frame's own rising edge closes it, since the serial clock may stop afterwards
	always_ff @(posedge FRAME_SELECT_N_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			hold_r <= ddsl_pkg::WORD_RST;
			frame_tog_r <= 1'b0;
		end else begin
			hold_r <= shift_r;
			frame_tog_r <= ~frame_tog_r;
		end
	end

	// ---------------------------------------------------------------
	// synchronisers into the system domain
	// ---------------------------------------------------------------
	logic [ddsl_pkg::SYNC_W-1:0] sync_in;
	logic [ddsl_pkg::SYNC_W-1:0] sync1_r;
	logic [ddsl_pkg::SYNC_W-1:0] sync2_r;
	logic [ddsl_pkg::SYNC_W-1:0] sync3_r;
	logic [ddsl_pkg::SYNC_W-1:0] stable_r;
	logic [ddsl_pkg::SYNC_W-1:0] stable_nxt;
	logic [ddsl_pkg::SYNC_W-1:0] agree;
	logic [ddsl_pkg::SYNC_W-1:0] change;

	always_comb begin
		sync_in = '0;
		sync_in[ddsl_pkg::SY_TOG] = frame_tog_r;
		sync_in[ddsl_pkg::SY_LOAD] = LOAD_OUTPUTS_N_I;
		sync_in[ddsl_pkg::SY_CODE] = CODING_SELECT_I;
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			sync1_r <= ddsl_pkg::SYNC_RST;
			sync2_r <= ddsl_pkg::SYNC_RST;
			sync3_r <= ddsl_pkg::SYNC_RST;
			stable_r <= ddsl_pkg::SYNC_RST;
		end else begin
			sync1_r <= sync_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			stable_r <= stable_nxt;
		end
	end

	// a change counts once the second and third stages agree
	assign agree = ~(sync2_r ^ sync3_r);
	assign stable_nxt = (sync3_r & agree) | (stable_r & ~agree);
	assign change = stable_nxt ^ stable_r;

	// range straps are pins too: three flops, taken once the last two agree
	logic [ddsl_pkg::NUM_CH-1:0] bip1_r;
	logic [ddsl_pkg::NUM_CH-1:0] bip2_r;
	logic [ddsl_pkg::NUM_CH-1:0] bip3_r;
	logic [ddsl_pkg::NUM_CH-1:0] bip_r;

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			bip1_r <= '0;
			bip2_r <= '0;
			bip3_r <= '0;
			bip_r <= '0;
		end else begin
			bip1_r <= BIPOLAR_I;
			bip2_r <= bip1_r;
			bip3_r <= bip2_r;
			bip_r <= (bip3_r & ~(bip2_r ^ bip3_r)) | (bip_r & (bip2_r ^ bip3_r));
		end
	end

	logic frame_evt;
	logic load_fall;
	logic load_low;
	logic offset_bin;

	assign frame_evt = change[ddsl_pkg::SY_TOG];
	assign load_fall = change[ddsl_pkg::SY_LOAD] && !stable_nxt[ddsl_pkg::SY_LOAD];
	assign load_low = !stable_r[ddsl_pkg::SY_LOAD];
	assign offset_bin = stable_r[ddsl_pkg::SY_CODE];

	// ---------------------------------------------------------------
	// word buffer between frame capture and register update
	// ---------------------------------------------------------------
	ddsl_fifo_if #(.W(ddsl_pkg::WORD_W)) fq ();

	ddsl_fifo #(
		.W(ddsl_pkg::WORD_W),
		.D(ddsl_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i(SYS_CLK_I),
		.arst_n_i(ARST_N_I),
		.f(fq.fifo)
	);

	logic [ddsl_pkg::WORD_W-1:0] push_data_r;
	logic push_valid_r;

	// hold the captured word until the buffer takes it; a newer frame while held overwrites it
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			push_data_r <= ddsl_pkg::WORD_RST;
			push_valid_r <= 1'b0;
		end else if (frame_evt) begin
			push_data_r <= hold_r;
			push_valid_r <= 1'b1;
		end else if (fq.wready) begin
			push_valid_r <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			OVERRUN_O <= 1'b0;
		end else if (frame_evt && push_valid_r && !fq.wready) begin
			OVERRUN_O <= 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			FIFO_FULL_O <= 1'b0;
		end else begin
			FIFO_FULL_O <= !fq.wready;
		end
	end

	assign fq.wdata = push_data_r;
	assign fq.wvalid = push_valid_r;
	// the drain stalls for the cycle of a simultaneous load
	assign fq.rready = !load_fall;

	// ---------------------------------------------------------------
	// input and output registers
	// ---------------------------------------------------------------
	ddsl_pkg::ddsl_code_t inp_r [ddsl_pkg::NUM_CH];
	ddsl_pkg::ddsl_code_t out_r [ddsl_pkg::NUM_CH];
	logic pop;
	logic [ddsl_pkg::NUM_CH-1:0] hit;
	ddsl_pkg::ddsl_code_t word_data;

	assign pop = fq.rvalid && fq.rready;
	assign word_data = fq.rdata[ddsl_pkg::DATA_LSB +: ddsl_pkg::DATA_W];

	always_comb begin
		hit = '0;
		for (int c = 0; c < ddsl_pkg::NUM_CH; c++) begin
			hit[c] = fq.rdata[ddsl_pkg::ALL_BIT] || (fq.rdata[ddsl_pkg::CHAN_BIT] == c[0]);
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			for (int c = 0; c < ddsl_pkg::NUM_CH; c++) begin
				inp_r[c] <= ddsl_pkg::CODE_RST;
			end
		end else if (pop) begin
			for (int c = 0; c < ddsl_pkg::NUM_CH; c++) begin
				if (hit[c]) begin
					inp_r[c] <= ddsl_pkg::ddsl_to_straight(word_data, bip_r[c],
						offset_bin);
				end
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			for (int c = 0; c < ddsl_pkg::NUM_CH; c++) begin
				out_r[c] <= ddsl_pkg::CODE_RST;
			end
			OUT_UPDATE_O <= 1'b0;
		end else if (load_fall) begin
			for (int c = 0; c < ddsl_pkg::NUM_CH; c++) begin
				out_r[c] <= inp_r[c];
			end
			OUT_UPDATE_O <= 1'b1;
		end else if (pop && load_low) begin
			for (int c = 0; c < ddsl_pkg::NUM_CH; c++) begin
				if (hit[c]) begin
					out_r[c] <= ddsl_pkg::ddsl_to_straight(word_data, bip_r[c],
						offset_bin);
				end
			end
			OUT_UPDATE_O <= 1'b1;
		end else begin
			OUT_UPDATE_O <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			DAC_A_O <= ddsl_pkg::CODE_RST;
			DAC_B_O <= ddsl_pkg::CODE_RST;
		end else begin
			DAC_A_O <= out_r[0];
			DAC_B_O <= out_r[1];
		end
	end
endmodule // ddsl_top

//--- hdl/ddsl_pkg.sv
package ddsl_pkg;

	// ---------------------------------------------------------------
	// serial word layout
	// ---------------------------------------------------------------
	localparam int WORD_W = 24;
	localparam int DATA_W = 16;
	localparam int DATA_LSB = 0;
	localparam int CHAN_BIT = 16;
	localparam int ALL_BIT = 18;
	localparam int NUM_CH = 2;

	// ---------------------------------------------------------------
	// buffering and synchronisers
	// ---------------------------------------------------------------
	localparam int FIFO_DEPTH = 4;
	localparam int SYNC_W = 3;
	localparam int SY_TOG = 0;
	localparam int SY_LOAD = 1;
	localparam int SY_CODE = 2;
	localparam logic [SYNC_W-1:0] SYNC_RST = 3'h0;

	// ---------------------------------------------------------------
	// reset values and coding
	// ---------------------------------------------------------------
	localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
	localparam logic [DATA_W-1:0] CODE_RST = 16'h0000;
	localparam logic [DATA_W-1:0] MSB_FLIP = 16'h8000;

	typedef logic [DATA_W-1:0] ddsl_code_t;

	// converts incoming data to the straight binary code that drives the converter
	function automatic ddsl_code_t ddsl_to_straight(input ddsl_code_t d, input logic bipolar,
		input logic offset_bin);
		ddsl_code_t r;
		r = d;
		if (bipolar && !offset_bin) begin
			r = d ^ MSB_FLIP;
		end
		return r;
	endfunction

endpackage

//--- hdl/ddsl_fifo_if.sv
`timescale 1ns/10ps
interface ddsl_fifo_if #(parameter int W = 24);
	logic [W-1:0] wdata;
	logic wvalid;
	logic wready;
	logic [W-1:0] rdata;
	logic rvalid;
	logic rready;

	modport fifo (input wdata, input wvalid, output wready, output rdata, output rvalid,
		input rready);
	modport prod (output wdata, output wvalid, input wready);
	modport cons (input rdata, input rvalid, output rready);
endinterface

//--- hdl/ddsl_fifo.sv
`timescale 1ns/10ps
module ddsl_fifo #(
	parameter int W = 24,
	parameter int D = 4
) (
	input wire logic clk_i,      // system clock
	input wire logic arst_n_i,   // asynchronous reset, active low
	ddsl_fifo_if.fifo f          // push and pop sides
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(D);
	localparam logic [AW-1:0] LAST_IDX = AW'(D - 1);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	assign f.wready = (cnt_r != FULL_CNT);
	assign f.rvalid = (cnt_r != '0);
	assign f.rdata = mem[rd_ptr_r];
	assign push = f.wvalid && f.wready;
	assign pop = f.rvalid && f.rready;

	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_r] <= f.wdata;
		end
	end

	// ---------------------------------------------------------------
	// pointers and fill level
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == LAST_IDX) ? '0 : wr_ptr_r + AW'(1);
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == LAST_IDX) ? '0 : rd_ptr_r + AW'(1);
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + (AW+1)'(1);
			end else if (pop && !push) begin
				cnt_r <= cnt_r - (AW+1)'(1);
			end
		end
	end
endmodule // ddsl_fifo

//--- tb/ddsl_top_assertions.sv
`timescale 1ns/10ps
module ddsl_top_assertions (
	input wire logic SYS_CLK_I, // system clock
	input wire logic ARST_N_I, // reset, active low
	input wire logic FRAME_SELECT_N_I, // frame select
	input wire logic LOAD_OUTPUTS_N_I, // load strobe
	input wire logic [15:0] DAC_A_O, // channel a
	input wire logic [15:0] DAC_B_O, // channel b
	input wire logic OUT_UPDATE_O // update pulse
);
	// ---------------------------------------------------------------
	// helpers and properties
	// ---------------------------------------------------------------
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!ARST_N_I);
	logic [3:0] hi_cnt_r;
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			hi_cnt_r <= 4'h0;
		end else if (!FRAME_SELECT_N_I) begin
			hi_cnt_r <= 4'h0;
		end else if (hi_cnt_r != 4'hf) begin
			hi_cnt_r <= hi_cnt_r + 4'h1;
		end
	end
	sequence s_fend;
		$rose(FRAME_SELECT_N_I) && !LOAD_OUTPUTS_N_I;
	endsequence
	sequence s_ldfall;
		$fell(LOAD_OUTPUTS_N_I) ##1 !LOAD_OUTPUTS_N_I [*2];
	endsequence
	property p_frame_upd;
		s_fend |-> ##[3:9] OUT_UPDATE_O;
	endproperty
	property p_hold_upd;
		LOAD_OUTPUTS_N_I [*6] |-> !OUT_UPDATE_O;
	endproperty
	property p_load_all;
		s_ldfall |-> ##[1:3] OUT_UPDATE_O;
	endproperty
	property p_idle_quiet;
		(hi_cnt_r >= 4'hc && !LOAD_OUTPUTS_N_I) [*8] |-> !OUT_UPDATE_O;
	endproperty
	property p_dac_cause;
		(!$stable(DAC_A_O) || !$stable(DAC_B_O)) |-> $past(OUT_UPDATE_O);
	endproperty
	property p_in_frame;
		!FRAME_SELECT_N_I [*8] |-> !OUT_UPDATE_O;
	endproperty
	property p_rst_clean;
		$rose(ARST_N_I) |-> DAC_A_O == 16'h0 && DAC_B_O == 16'h0 && !OUT_UPDATE_O;
	endproperty
	a_frame_upd: assert property (p_frame_upd)
		else $error("no update after frame end");
	a_hold_upd: assert property (p_hold_upd)
		else $error("update while load strobe high");
	a_load_all: assert property (p_load_all)
		else $error("no update after load strobe fall");
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("update while link idle");
	a_dac_cause: assert property (p_dac_cause)
		else $error("output changed without update pulse");
	a_in_frame: assert property (p_in_frame)
		else $error("update inside a frame");
	a_rst_clean: assert property (p_rst_clean)
		else $error("outputs not clear after reset");
endmodule // ddsl_top_assertions
bind ddsl_top ddsl_top_assertions u_chk (.SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I),
	.FRAME_SELECT_N_I(FRAME_SELECT_N_I), .LOAD_OUTPUTS_N_I(LOAD_OUTPUTS_N_I),
	.DAC_A_O(DAC_A_O), .DAC_B_O(DAC_B_O), .OUT_UPDATE_O(OUT_UPDATE_O));

//--- tb/ddsl_host.sv
`timescale 1ns/10ps
module ddsl_host (
	output logic sclk_o, // serial clock
	output logic frame_select_n_o, // frame select
	output logic serial_data_in_o // serial data
);
	initial begin
		sclk_o = 1'b1;
		frame_select_n_o = 1'b1;
		serial_data_in_o = 1'b0;
	end
	// sends the low n bits of w, msb first; clock idles high
	// the bench link runs a 15 ns period to stress the shift path above the host limit
	task automatic send(input logic [23:0] w, input int n);
		frame_select_n_o = 1'b0;
		#7.5;
		for (int i = n - 1; i >= 0; i--) begin
			serial_data_in_o = w[i];
			#7.5 sclk_o = 1'b0;
			#7.5 sclk_o = 1'b1;
		end
		#7.5 frame_select_n_o = 1'b1;
		serial_data_in_o = ~serial_data_in_o;
	endtask
	// clock and data activity with the frame closed
	task automatic stray(input int n);
		for (int i = 0; i < n; i++) begin
			serial_data_in_o = ~serial_data_in_o;
			#7.5 sclk_o = 1'b0;
			#7.5 sclk_o = 1'b1;
		end
	endtask
endmodule // ddsl_host

//--- tb/tb.sv
`timescale 1ns/10ps
module tb;
	logic clk, arst_n, sclk, fs_n, sdi, ld_n, code_sel, upd, full, ovr, ok;
	logic [1:0] bip;
	logic [15:0] dac_a, dac_b;
	int err_total, n_tests, cyc;
	always #12.5 clk = ~clk;
	ddsl_host host (.sclk_o(sclk), .frame_select_n_o(fs_n), .serial_data_in_o(sdi));
	ddsl_top DUT (.SYS_CLK_I(clk), .ARST_N_I(arst_n), .SCLK_I(sclk), .FRAME_SELECT_N_I(fs_n),
		.SERIAL_DATA_IN_I(sdi), .LOAD_OUTPUTS_N_I(ld_n), .CODING_SELECT_I(code_sel),
		.BIPOLAR_I(bip), .DAC_A_O(dac_a), .DAC_B_O(dac_b), .OUT_UPDATE_O(upd),
		.FIFO_FULL_O(full), .OVERRUN_O(ovr));
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wait_upd();
		ok = 1'b0;
		for (int i = 0; i < 40 && !ok; i++) begin
			@(posedge clk);
			#1 ok = (upd === 1'b1);
		end
		@(posedge clk);
		#1 chk("update pulse", 16'h1, {15'h0, ok});
	endtask
	task dir(input logic ch, input logic [1:0] b, input logic c, input logic [15:0] d, e);
		@(posedge clk);
		bip <= b;
		code_sel <= c;
		#120 host.send({7'h0, ch, d}, 24);
		wait_upd();
		chk(ch ? "dac b" : "dac a", e, ch ? dac_b : dac_a);
	endtask
	task t_direct();
		dir(1'b0, 2'b00, 1'b0, 16'h1234, 16'h1234);
		dir(1'b1, 2'b10, 1'b0, 16'h0005, 16'h8005);
		dir(1'b1, 2'b10, 1'b1, 16'h7000, 16'h7000);
		dir(1'b0, 2'b01, 1'b0, 16'h8000, 16'h0000);
		$display("t_direct done");
	endtask
	task t_defer();
		@(posedge clk);
		ld_n <= 1'b1;
		bip <= 2'b00;
		#150 host.send(24'h00aaaa, 24);
		#120 host.send(24'h015555, 24);
		repeat (12) @(posedge clk);
		chk("held a", 16'h0000, dac_a);
		chk("held b", 16'h7000, dac_b);
		ld_n <= 1'b0;
		wait_upd();
		chk("load a", 16'haaaa, dac_a);
		chk("load b", 16'h5555, dac_b);
		$display("t_defer done");
	endtask
	task t_idle();
		dir(1'b0, 2'b00, 1'b0, 16'h00cd, 16'h00cd);
		host.stray(10);
		#120 host.send(24'h00003e, 8);
		wait_upd();
		chk("short frame", 16'hcd3e, dac_a);
		chk("fifo full", 16'h0, {15'h0, full});
		chk("overrun", 16'h0, {15'h0, ovr});
		$display("t_idle done");
	endtask
	task close_out();
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			$display("[ERR] run time expected below 5000 cycles");
			close_out();
		end
	end
	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		ld_n = 1'b0;
		code_sel = 1'b0;
		bip = 2'b00;
		err_total = 0;
		n_tests = 0;
		cyc = 0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_direct();
		t_defer();
		t_idle();
		close_out();
	end
endmodule // tb
